// ===== retx_pkg.sv
// Shared constants for the retransmit-from-mark FIFO block.
// Assumes a single 40 MHz APB clock; every pin is sampled on that clock.
package retx_pkg;
  // Storage geometry, deepest variant, single-rate view
  localparam int AW = 17;
  localparam int DW = 40;
  localparam logic [AW:0] DEPTH = 18'h20000;
  // Serial offset load lengths
  localparam int OFF_W_SDR = 17;
  localparam int OFF_W_DDR = 16;
  localparam logic [5:0] SER_BITS_SDR = 6'h22;
  localparam logic [5:0] SER_BITS_DDR = 6'h20;
  localparam int SER_W = 34;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MARK = 8'h08;
  localparam logic [7:0] REG_LEVEL = 8'h0C;
  localparam logic [7:0] REG_EOFF = 8'h10;
  localparam logic [7:0] REG_FOFF = 8'h14;
  // Control field positions
  localparam int CTRL_FIRST_WORD_FALLTHROUGH = 0;
  localparam int CTRL_WSR_N = 1;
  localparam int CTRL_RSR_N = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status field positions
  localparam int ST_RETX = 0;
  localparam int ST_MARKED = 1;
  localparam int ST_SETUP = 2;
  localparam int ST_LOADED = 3;
  // Read side sequencing states
  typedef enum logic [1:0] {RS_IDLE, RS_SETUP, RS_LOAD} rd_state_t;
endpackage

// ===== pin_sync.sv
// Two-flop synchroniser with edge pulses for a group of pins.
// Assumes inputs are asynchronous to clk; pulses last one clk cycle.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin side
  input wire logic [W-1:0] d,
  // Synchronised side
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r; // First stage, read only by q
  logic [W-1:0] prev_r; // Delayed copy for edge detection

  // Synchroniser chain and edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
      prev_r <= q;
    end
  end

  // Edge pulses from the stable stage only
  assign rise = q & ~prev_r;
  assign fall = ~q & prev_r;
endmodule
`default_nettype wire

// ===== offset_loader.sv
// Serial loader for the empty and full flag offsets.
// Assumes sclk_rise is a one-cycle pulse per serial clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module offset_loader (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial port, synchronised
  input wire logic sclk_rise,
  input wire logic serial_load_enable_n,
  input wire logic serial_in,
  // Either port at double rate shortens the words
  input wire logic ddr,
  // Loaded offsets
  output logic [retx_pkg::OFF_W_SDR-1:0] empty_off,
  output logic [retx_pkg::OFF_W_SDR-1:0] full_off,
  output logic loaded
);
  logic [retx_pkg::SER_W-1:0] sr_r; // Shift-right, LSB arrives first
  logic [retx_pkg::SER_W-1:0] sr_nxt;
  logic [5:0] cnt_r; // Bits taken so far
  logic [5:0] total;

  assign sr_nxt = {serial_in, sr_r[retx_pkg::SER_W-1:1]};
  assign total = ddr ? retx_pkg::SER_BITS_DDR : retx_pkg::SER_BITS_SDR;

  // One bit per serial edge; commit only a complete set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= '0;
      cnt_r <= '0;
      empty_off <= '0;
      full_off <= '0;
      loaded <= 1'b0;
    end else if (serial_load_enable_n) begin
      // Dropping enable abandons a partial set
      cnt_r <= '0;
    end else if (sclk_rise) begin
      sr_r <= sr_nxt;
      if (cnt_r == total - 6'h01) begin
        cnt_r <= '0;
        loaded <= 1'b1;
        if (ddr) begin
          // Empty first, full last, both 16 bits
          empty_off <= {1'b0, sr_nxt[17:2]};
          full_off <= {1'b0, sr_nxt[33:18]};
        end else begin
          empty_off <= sr_nxt[16:0];
          full_off <= sr_nxt[33:17];
        end
      end else begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== retx_fifo.sv
// FIFO core with mark and retransmit, double-rate ports and APB status.
// Assumes all FIFO pins are asynchronous and slow against pclk.
`timescale 1ns/1ps
`default_nettype none
module retx_fifo (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Write port pins
  input wire logic write_clk,
  input wire logic write_enable_n,
  input wire logic write_chip_select_n,
  input wire logic [retx_pkg::DW-1:0] data_in,
  // Read port pins
  input wire logic read_clk,
  input wire logic read_enable_n,
  input wire logic mark,
  input wire logic retransmit_n,
  // Serial offset port
  input wire logic serial_clk,
  input wire logic serial_load_enable_n,
  input wire logic serial_in,
  // Data and flags
  output logic [retx_pkg::DW-1:0] data_out,
  output logic empty_flag_n,
  output logic output_ready_n,
  output logic full_flag_n
);
  localparam int AW = retx_pkg::AW;
  localparam int DW = retx_pkg::DW;
  localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1}; // Pointer step at full pointer width

  // Synchronised pins and edges
  logic [5:0] ctl_q;
  logic ignore_q3, ignore_q2, ignore_q1, ignore_r0, ignore_f1, ignore_f0; // Unused synchroniser taps
  logic [DW-1:0] din_q;
  logic wclk_rise, wclk_fall, rclk_rise, rclk_fall, sclk_rise;
  logic wen_n_s, wcs_n_s, ren_n_s, mark_s, rt_n_s;
  logic sen_n_s, si_s;

  // Control register and derived modes
  logic [2:0] ctrl_r; // Fall-through, write rate, read rate
  logic first_word_fallthrough_eff; // Effective fall-through mode
  logic ddr_w, ddr_r; // Double-rate ports

  // Storage, pairs of words at double rate
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wptr_r, rptr_r; // Wrap bit on top
  logic [AW:0] level; // Words held
  logic [AW:0] rewind; // Read pointer back at mark
  logic [AW-1:0] mark_dist;
  logic [AW-1:0] last_rd_r; // Address of word in output register
  logic w_ev, w_ok, r_ev, rd_ok, rt_go, enter;

  // Mark state
  logic retx_r, mark_valid_r;
  logic [AW-1:0] mark_addr_r;
  retx_pkg::rd_state_t rstate_r;

  // Offsets from the serial loader
  logic [retx_pkg::OFF_W_SDR-1:0] empty_off, full_off;
  logic off_loaded;

  // APB request decode
  logic setup_ph, acc_wr, ro_hit, map_hit;
  logic [31:0] rd_mux;

  // Control pins: write enable, chip select, read enable, mark, rt, load
  pin_sync #(.W(6)) u_ctl (
    .clk(pclk),
    .rst_n(presetn),
    .d({write_enable_n, write_chip_select_n, read_enable_n, mark, retransmit_n, serial_load_enable_n}),
    .q(ctl_q),
    .rise(),
    .fall()
  );
  // Clock pins and serial data, sampled as ordinary inputs
  pin_sync #(.W(4)) u_clk (
    .clk(pclk),
    .rst_n(presetn),
    .d({write_clk, read_clk, serial_clk, serial_in}),
    .q({ignore_q3, ignore_q2, ignore_q1, si_s}),
    .rise({wclk_rise, rclk_rise, sclk_rise, ignore_r0}),
    .fall({wclk_fall, rclk_fall, ignore_f1, ignore_f0})
  );
  // Data bus, same latency as the clock pins so edges see aligned data
  pin_sync #(.W(DW)) u_din (
    .clk(pclk),
    .rst_n(presetn),
    .d(data_in),
    .q(din_q),
    .rise(),
    .fall()
  );
  assign {wen_n_s, wcs_n_s, ren_n_s, mark_s, rt_n_s, sen_n_s} = ctl_q;

  // Serial flag offsets
  offset_loader u_off (
    .clk(pclk),
    .rst_n(presetn),
    .sclk_rise(sclk_rise),
    .serial_load_enable_n(sen_n_s),
    .serial_in(si_s),
    .ddr(ddr_w | ddr_r),
    .empty_off(empty_off),
    .full_off(full_off),
    .loaded(off_loaded)
  );

  // Mode decode; a single-rate pin held low selects single rate
  assign ddr_w = ctrl_r[retx_pkg::CTRL_WSR_N];
  assign ddr_r = ctrl_r[retx_pkg::CTRL_RSR_N];
  assign first_word_fallthrough_eff = ctrl_r[retx_pkg::CTRL_FIRST_WORD_FALLTHROUGH] & ~ddr_w & ~ddr_r;

  // Occupancy and events
  assign level = wptr_r - rptr_r;
  assign w_ev = wclk_rise | (ddr_w & wclk_fall);
  // Block writes at the mark so replay data survives
  assign w_ok = w_ev & ~wen_n_s & ~wcs_n_s & ~level[AW]
    & ~(mark_valid_r & (wptr_r[AW-1:0] == mark_addr_r));
  assign r_ev = rclk_rise | (ddr_r & rclk_fall);
  assign rd_ok = r_ev & ~ren_n_s & (level != '0);
  // Retransmit only once a mark exists
  assign rt_go = rclk_rise & ~rt_n_s & mark_valid_r;
  assign mark_dist = rptr_r[AW-1:0] - mark_addr_r;
  assign rewind = rptr_r - {1'b0, mark_dist};
  // Entry needs data in the output register at fall-through, a non-empty FIFO otherwise
  assign enter = rclk_rise & mark_s & ~retx_r
    & (first_word_fallthrough_eff ? ~output_ready_n : empty_flag_n);

  // Write side: memory and write pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= '0;
    end else if (w_ok) begin
      wptr_r <= wptr_r + PTR_ONE;
    end
  end
  // Storage array has no reset
  always_ff @(posedge pclk) begin
    if (w_ok) begin
      mem[wptr_r[AW-1:0]] <= din_q;
    end
  end

  // Mark capture and retransmit mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retx_r <= 1'b0;
      mark_valid_r <= 1'b0;
      mark_addr_r <= '0;
    end else if (rclk_rise && !mark_s) begin
      // Leaving the mode also lifts write protection
      retx_r <= 1'b0;
      mark_valid_r <= 1'b0;
    end else if (enter) begin
      retx_r <= 1'b1;
      mark_valid_r <= 1'b1;
      // Pair-align at double rate: replay starts at rising word
      mark_addr_r <= ddr_r ? {last_rd_r[AW-1:1], 1'b0} : last_rd_r;
    end
  end

  // Read side: pointer, output register, empty and ready flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr_r <= '0;
      last_rd_r <= '0;
      data_out <= '0;
      empty_flag_n <= 1'b0;
      output_ready_n <= 1'b1;
      rstate_r <= retx_pkg::RS_IDLE;
    end else if (rt_go) begin
      // Setup start blocks reads on either mode's flag
      rptr_r <= rewind;
      rstate_r <= retx_pkg::RS_SETUP;
      empty_flag_n <= 1'b0;
      output_ready_n <= 1'b1;
    end else begin
      case (rstate_r)
        retx_pkg::RS_SETUP: begin
          if (rclk_rise) begin
            rstate_r <= first_word_fallthrough_eff ? retx_pkg::RS_LOAD : retx_pkg::RS_IDLE;
            empty_flag_n <= 1'b1;
            output_ready_n <= ~first_word_fallthrough_eff;
          end
        end
        retx_pkg::RS_LOAD: begin
          // First replayed word loads without a read request
          if (rclk_rise) begin
            data_out <= mem[rptr_r[AW-1:0]];
            last_rd_r <= rptr_r[AW-1:0];
            rptr_r <= rptr_r + PTR_ONE;
            rstate_r <= retx_pkg::RS_IDLE;
          end
        end
        retx_pkg::RS_IDLE: begin
          if (first_word_fallthrough_eff) begin
            // Fall-through: refill an empty output register
            if (rclk_rise && (output_ready_n || !ren_n_s)) begin
              if (level != '0) begin
                data_out <= mem[rptr_r[AW-1:0]];
                last_rd_r <= rptr_r[AW-1:0];
                rptr_r <= rptr_r + PTR_ONE;
                output_ready_n <= 1'b0;
              end else begin
                output_ready_n <= 1'b1;
              end
            end
            empty_flag_n <= 1'b1;
          end else begin
            if (rd_ok) begin
              data_out <= mem[rptr_r[AW-1:0]];
              last_rd_r <= rptr_r[AW-1:0];
              rptr_r <= rptr_r + PTR_ONE;
            end
            // Flag lags the pointers by one pclk
            empty_flag_n <= (level != '0);
            output_ready_n <= 1'b1;
          end
        end
        default: begin
          rstate_r <= retx_pkg::RS_IDLE;
        end
      endcase
    end
  end

  // Full flag, registered from occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_flag_n <= 1'b1;
    end else begin
      full_flag_n <= (level != retx_pkg::DEPTH);
    end
  end

  // APB decode: no wait state, answer set up in the setup cycle
  assign setup_ph = psel & ~penable;
  assign acc_wr = psel & penable & pready & pwrite & ~pslverr;
  assign map_hit = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0)
    && (paddr[7:0] <= retx_pkg::REG_FOFF);
  assign ro_hit = map_hit && (paddr[7:0] != retx_pkg::REG_CTRL);

  // Read data selection
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr[7:0])
      retx_pkg::REG_CTRL: rd_mux = {29'h0, ctrl_r};
      retx_pkg::REG_STATUS: rd_mux = {28'h0, off_loaded, rstate_r != retx_pkg::RS_IDLE, mark_valid_r, retx_r};
      retx_pkg::REG_MARK: rd_mux = {15'h0, mark_addr_r};
      retx_pkg::REG_LEVEL: rd_mux = {14'h0, level};
      retx_pkg::REG_EOFF: rd_mux = {15'h0, empty_off};
      retx_pkg::REG_FOFF: rd_mux = {15'h0, full_off};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pready <= 1'b1;
      prdata <= (map_hit && !pwrite) ? rd_mux : 32'h00000000;
      // Unmapped, or a write to any register but control
      pslverr <= !map_hit || (pwrite && ro_hit);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= retx_pkg::CTRL_RESET;
    end else if (acc_wr && paddr[7:0] == retx_pkg::REG_CTRL) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rt_start;
    rt_go && rstate_r == retx_pkg::RS_IDLE && !first_word_fallthrough_eff;
  endsequence
  sequence s_setup_done;
    !empty_flag_n ##1 (rstate_r == retx_pkg::RS_SETUP && rclk_rise && !rt_go) ##1 empty_flag_n;
  endsequence
  property p_ef_setup;
    s_rt_start |=> !empty_flag_n && rstate_r == retx_pkg::RS_SETUP;
  endproperty
  a_ef_setup: assert property (p_ef_setup) else $error("empty flag not low at setup");
  property p_ef_release;
    rstate_r == retx_pkg::RS_SETUP && rclk_rise && !rt_go && !first_word_fallthrough_eff |=> empty_flag_n;
  endproperty
  a_ef_release: assert property (p_ef_release) else $error("empty flag not released");
  property p_rewind;
    rt_go |=> rptr_r[AW-1:0] == $past(mark_addr_r);
  endproperty
  a_rewind: assert property (p_rewind) else $error("read pointer not at mark");
  property p_no_mark;
    rclk_rise && !rt_n_s && !mark_valid_r && ren_n_s && rstate_r == retx_pkg::RS_IDLE && !first_word_fallthrough_eff
      |=> rptr_r == $past(rptr_r);
  endproperty
  a_no_mark: assert property (p_no_mark) else $error("retransmit acted without mark");
  property p_exit;
    rclk_rise && !mark_s |=> !retx_r && !mark_valid_r;
  endproperty
  a_exit: assert property (p_exit) else $error("mode kept with mark low");
  property p_enter;
    enter |=> retx_r && mark_valid_r && mark_addr_r == (ddr_r ? {$past(last_rd_r[AW-1:1]), 1'b0} : $past(last_rd_r));
  endproperty
  a_enter: assert property (p_enter) else $error("mark not captured");
  property p_pair;
    enter && ddr_r |=> !mark_addr_r[0];
  endproperty
  a_pair: assert property (p_pair) else $error("double-rate mark not pair aligned");
  property p_protect;
    mark_valid_r && wptr_r[AW-1:0] == mark_addr_r |=> wptr_r == $past(wptr_r);
  endproperty
  a_protect: assert property (p_protect) else $error("write pointer passed the mark");
  property p_first_word_fallthrough_load;
    rstate_r == retx_pkg::RS_LOAD && rclk_rise && !rt_go |=> rptr_r == $past(rptr_r) + PTR_ONE && !output_ready_n;
  endproperty
  a_first_word_fallthrough_load: assert property (p_first_word_fallthrough_load) else $error("first replay word not loaded");
  property p_first_word_fallthrough_sdr;
    (ddr_w || ddr_r) && rstate_r == retx_pkg::RS_IDLE |=> output_ready_n;
  endproperty
  a_first_word_fallthrough_sdr: assert property (p_first_word_fallthrough_sdr) else $error("fall-through at double rate");
  property p_setup_seq;
    s_rt_start ##[1:100] (rstate_r == retx_pkg::RS_SETUP && rclk_rise && !rt_go) |=> empty_flag_n;
  endproperty
  a_setup_seq: assert property (p_setup_seq) else $error("setup sequence broken");
endmodule
`default_nettype wire

// ===== fifo_far_end.sv
// Far-end model: writer, reader and serial programmer on the FIFO pins.
// Assumes pclk paces every pin edge; each level lasts at least HOLD pclk cycles.
`timescale 1ns/1ps
`default_nettype none
module fifo_far_end #(
  parameter int HOLD = 6
) (
  // Pacing clock
  input wire logic pclk,
  // Write port
  output logic write_clk,
  output logic write_enable_n,
  output logic write_chip_select_n,
  output logic [retx_pkg::DW-1:0] data_in,
  // Read port
  output logic read_clk,
  output logic read_enable_n,
  output logic mark,
  output logic retransmit_n,
  // Serial port
  output logic serial_clk,
  output logic serial_load_enable_n,
  output logic serial_in
);
  // Idle levels; pin clocks stand still between transfers
  initial begin
    write_clk = 1'b0;
    write_enable_n = 1'b1;
    write_chip_select_n = 1'b1;
    data_in = '0;
    read_clk = 1'b0;
    read_enable_n = 1'b1;
    mark = 1'b0;
    retransmit_n = 1'b1;
    serial_clk = 1'b0;
    serial_load_enable_n = 1'b1;
    serial_in = 1'b0;
  end

  // Pacing delay
  task automatic gap(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One write clock period; second word lands only at double rate
  task automatic wr(input logic [retx_pkg::DW-1:0] d0, input logic [retx_pkg::DW-1:0] d1);
    data_in <= d0;
    write_enable_n <= 1'b0;
    write_chip_select_n <= 1'b0;
    gap(HOLD);
    write_clk <= 1'b1;
    gap(HOLD);
    data_in <= d1;
    gap(HOLD);
    write_clk <= 1'b0;
    gap(HOLD);
    write_enable_n <= 1'b1;
    write_chip_select_n <= 1'b1;
    // Released bus shows no stale word
    data_in <= ~d1;
    gap(HOLD);
  endtask

  // One read clock period; mark level persists afterwards
  task automatic rd(input logic ren_n, input logic mk, input logic rt_n);
    retransmit_n <= rt_n;
    // Reads stay disabled whenever retransmit is requested
    read_enable_n <= rt_n ? ren_n : 1'b1;
    mark <= mk;
    gap(HOLD);
    read_clk <= 1'b1;
    gap(HOLD);
    read_clk <= 1'b0;
    // Enable stands past the falling edge so a double-rate read takes it
    gap(HOLD);
    read_enable_n <= 1'b1;
    retransmit_n <= 1'b1;
    gap(HOLD);
  endtask

  // Offset stream, least significant bit first
  task automatic ser(input logic [retx_pkg::SER_W-1:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in <= bits[i];
      serial_load_enable_n <= 1'b0;
      gap(HOLD);
      serial_clk <= 1'b1;
      gap(HOLD);
      serial_clk <= 1'b0;
    end
    gap(HOLD);
    serial_load_enable_n <= 1'b1;
    serial_in <= ~bits[n-1];
    gap(HOLD);
  endtask
endmodule
`default_nettype wire

// ===== fifo_retransmit_from_mark_bench.sv
// Self-checking bench for the retransmit FIFO block.
// Assumes the far-end model drives all pins; APB driven here.
`timescale 1ns/1ps
`default_nettype none
module fifo_retransmit_from_mark_bench;
  // APB side
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  // Pin side
  logic write_clk, write_enable_n, write_chip_select_n, read_clk, read_enable_n, mark, retransmit_n;
  logic serial_clk, serial_load_enable_n, serial_in, empty_flag_n, output_ready_n, full_flag_n;
  logic [retx_pkg::DW-1:0] data_in, data_out;
  // Bookkeeping
  int err_total, n_compared;
  logic [retx_pkg::DW-1:0] wq [0:39];
  logic [31:0] rdv;
  logic errv;
  logic [33:0] sbits;

  retx_fifo uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_clk(write_clk), .write_enable_n(write_enable_n), .write_chip_select_n(write_chip_select_n),
    .data_in(data_in), .read_clk(read_clk), .read_enable_n(read_enable_n), .mark(mark),
    .retransmit_n(retransmit_n), .serial_clk(serial_clk), .serial_load_enable_n(serial_load_enable_n),
    .serial_in(serial_in), .data_out(data_out), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n), .full_flag_n(full_flag_n));

  fifo_far_end far (.pclk(pclk), .write_clk(write_clk), .write_enable_n(write_enable_n),
    .write_chip_select_n(write_chip_select_n), .data_in(data_in), .read_clk(read_clk),
    .read_enable_n(read_enable_n), .mark(mark), .retransmit_n(retransmit_n), .serial_clk(serial_clk),
    .serial_load_enable_n(serial_load_enable_n), .serial_in(serial_in));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Expected offset field of a serial stream
  function automatic logic [31:0] off_field(input logic [33:0] s, input int lo, input int w);
    return 32'((s >> lo) & ((34'h1 << w) - 34'h1));
  endfunction

  // Compare and count
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready with no bound of its own
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends the wait for a silent slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register read with comparison
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, exp, rdv);
  endtask

  // Read one word (a pair at double rate) with read enable and compare
  task automatic rd_word(input int idx, input logic mk);
    far.rd(1'b0, mk, 1'b1);
    check("data_out", wq[idx], data_out);
  endtask

  // Reset pulse, then wait out the pin sync pipeline
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // Per-test summary
  task automatic end_test(input string t);
    $display("test %s ended: %0d compared, %0d errors", t, n_compared, err_total);
  endtask

  // Single place where the run ends
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, about ten times the expected run
  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'h865D));
    do_reset();
    // Reset values, read-only and unmapped refusals
    check("empty", 1'b0, empty_flag_n);
    check("ready", 1'b1, output_ready_n);
    check("full", 1'b1, full_flag_n);
    check("data_out", 40'h0, data_out);
    rreg(retx_pkg::REG_CTRL, 32'h0, "ctrl");
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", 1'b1, errv);
    apb(1'b1, retx_pkg::REG_STATUS, 32'hF);
    check("ro err", 1'b1, errv);
    rreg(retx_pkg::REG_STATUS, 32'h0, "status");
    end_test("registers");
    // Single-rate offset stream
    sbits = 34'({$urandom(), $urandom()});
    far.ser(sbits, 34);
    rreg(retx_pkg::REG_EOFF, off_field(sbits, 0, 17), "eoff");
    rreg(retx_pkg::REG_FOFF, off_field(sbits, 17, 17), "foff");
    rreg(retx_pkg::REG_STATUS, 32'h8, "loaded");
    end_test("serial");
    // Standard mode: fill, well over 32 words ahead of the mark
    for (int i = 0; i < 40; i++) begin
      wq[i] = 40'({$urandom(), $urandom()});
      far.wr(wq[i], ~wq[i]);
    end
    rreg(retx_pkg::REG_LEVEL, 32'h28, "level");
    for (int i = 0; i < 5; i++) begin
      rd_word(i, 1'b0);
    end
    far.rd(1'b1, 1'b1, 1'b1);
    rreg(retx_pkg::REG_STATUS, 32'hB, "mode");
    rreg(retx_pkg::REG_MARK, 32'h4, "mark");
    for (int i = 5; i < 8; i++) begin
      rd_word(i, 1'b1);
    end
    far.rd(1'b1, 1'b1, 1'b0);
    check("setup", 1'b0, empty_flag_n);
    far.rd(1'b1, 1'b1, 1'b1);
    check("setup done", 1'b1, empty_flag_n);
    rd_word(4, 1'b1);
    rd_word(5, 1'b1);
    far.rd(1'b1, 1'b0, 1'b1);
    rreg(retx_pkg::REG_STATUS, 32'h8, "left");
    far.rd(1'b1, 1'b0, 1'b0);
    check("ignored", wq[5], data_out);
    check("ignored flag", 1'b1, empty_flag_n);
    far.rd(1'b1, 1'b1, 1'b1);
    rreg(retx_pkg::REG_MARK, 32'h5, "remark");
    rd_word(6, 1'b1);
    far.rd(1'b1, 1'b1, 1'b0);
    far.rd(1'b1, 1'b1, 1'b1);
    rd_word(5, 1'b1);
    end_test("standard");
    // Double rate: two words per write clock, shorter stream
    do_reset();
    apb(1'b1, retx_pkg::REG_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wq[2*i] = 40'({$urandom(), $urandom()});
      wq[2*i+1] = 40'({$urandom(), $urandom()});
      far.wr(wq[2*i], wq[2*i+1]);
    end
    rreg(retx_pkg::REG_LEVEL, 32'h8, "ddr level");
    far.ser(sbits, 32);
    rreg(retx_pkg::REG_EOFF, off_field(sbits, 0, 16), "ddr eoff");
    rreg(retx_pkg::REG_FOFF, off_field(sbits, 16, 16), "ddr foff");
    apb(1'b1, retx_pkg::REG_CTRL, 32'h3);
    rreg(retx_pkg::REG_CTRL, 32'h3, "ctrl rw");
    check("no first_word_fallthrough", 1'b1, output_ready_n);
    check("std flag", 1'b1, empty_flag_n);
    // Both ports double rate: a pair per read clock, mark after a falling-edge read
    apb(1'b1, retx_pkg::REG_CTRL, 32'h6);
    rd_word(1, 1'b0);
    rd_word(3, 1'b0);
    far.rd(1'b1, 1'b1, 1'b1);
    rreg(retx_pkg::REG_MARK, 32'h2, "pair mark");
    far.rd(1'b1, 1'b1, 1'b0);
    far.rd(1'b1, 1'b1, 1'b1);
    rd_word(3, 1'b1);
    end_test("double rate");
    // Fall-through retransmit
    do_reset();
    apb(1'b1, retx_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 10; i++) begin
      wq[i] = 40'({$urandom(), $urandom()});
      far.wr(wq[i], ~wq[i]);
    end
    repeat (3) far.rd(1'b1, 1'b0, 1'b1);
    check("fell through", wq[0], data_out);
    check("or low", 1'b0, output_ready_n);
    rd_word(1, 1'b0);
    rd_word(2, 1'b0);
    far.rd(1'b1, 1'b1, 1'b1);
    apb(1'b0, retx_pkg::REG_STATUS, 32'h0);
    check("first_word_fallthrough mode", 2'b11, rdv[1:0]);
    rd_word(3, 1'b1);
    rd_word(4, 1'b1);
    far.rd(1'b1, 1'b1, 1'b0);
    check("or setup", 1'b1, output_ready_n);
    far.rd(1'b1, 1'b1, 1'b1);
    check("or done", 1'b0, output_ready_n);
    far.rd(1'b1, 1'b1, 1'b1);
    check("auto load", wq[2], data_out);
    rd_word(3, 1'b1);
    end_test("fall through");
    report_and_stop();
  end
endmodule
`default_nettype wire
